// *** rtl/continuous_preamble_tx.sv ***
// Operation
// - generator index moves only while its read enable is high
// - frequency and midamble generators reuse the same counter-table module
// - phase midamble per coding rate is a cyclic shift of one base
// - continuous mode sends gain preamble then repeated timing preambles
// - timing repeats per frame come from the subframe count input
// - gain table is 256 symbols at oversampling 2
// - timing table is 512 symbols at oversampling 2
// - transmit permit is held high by software while sending allowed
// - stop flag marks end of permit and ends continuous sending
// - select output picks which segment feeds the shaping filter
// - shaping filter input is the assembled frame sample stream
// - root raised cosine filter with run-time roll-off select
// - roll-off 0.22 when select is one, else 0.35
// - filtered samples are converted to unsigned dac format
// - frequency preamble length is 544, 1056 or 2080 by select
// - phase midamble is 166 symbols at oversampling 2
`timescale 1ns/1ns
`default_nettype none
module continuous_preamble_tx #(
   parameter int REPEAT_W = 16
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst,
   // software control
   input  wire logic                        tx_enable,
   input  wire logic                        tx_end,
   input  wire logic [REPEAT_W-1:0]         num_subframes,
   input  wire logic                        alpha_sel,
   input  wire logic [1:0]                  freq_sel,
   input  wire logic [1:0]                  rate_sel,
   input  wire logic                        freq_en,
   input  wire logic                        phase_en,
   // status
   output preamble_pkg::seg_sel_t           tx_select,
   output logic                             gain_en,
   output logic                             timing_en,
   output logic                             busy,
   // side generator outputs
   output preamble_pkg::iq_t                freq_sample,
   output preamble_pkg::iq_t                phase_sample,
   // dac stream
   output preamble_pkg::dac_t               dac_data,
   output logic                             dac_valid
);
   if (REPEAT_W < 1 || REPEAT_W > 16)
   begin : g_bad_repeat
      $error("repeat width out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_GAIN   = 2'b01,
      ST_TIMING = 2'b10
   } state_t;

   localparam int IW = preamble_pkg::IDX_W;

   state_t                state_q;
   state_t                state_d;
   logic [REPEAT_W-1:0]   rep_q;
   logic                  stop_q;
   logic                  gain_last;
   logic                  timing_last;
   logic                  freq_last;
   logic                  phase_last;
   preamble_pkg::iq_t     gain_s;
   preamble_pkg::iq_t     timing_s;
   preamble_pkg::iq_t     freq_s;
   preamble_pkg::iq_t     phase_s;
   preamble_pkg::iq_t     seg_s;
   logic [IW-1:0]         freq_len;
   logic [IW-1:0]         phase_shift;

   lut_generator #(.IDX_W(IW), .SEED(8'h5A)) gain_gen (
      .clock(clock), .rst(rst), .read_en(gain_en),
      .length(IW'(preamble_pkg::GAIN_LEN)), .shift('0),
      .sample(gain_s), .last(gain_last));

   lut_generator #(.IDX_W(IW), .SEED(8'hA3)) timing_gen (
      .clock(clock), .rst(rst), .read_en(timing_en),
      .length(IW'(preamble_pkg::TIMING_LEN)), .shift('0),
      .sample(timing_s), .last(timing_last));

   always_comb
   begin
      case (freq_sel)
         2'h0: freq_len = IW'(preamble_pkg::FREQ_LEN_0);
         2'h1: freq_len = IW'(preamble_pkg::FREQ_LEN_1);
         default: freq_len = IW'(preamble_pkg::FREQ_LEN_2);
      endcase
   end

   lut_generator #(.IDX_W(IW), .SEED(8'h3C)) freq_gen (
      .clock(clock), .rst(rst), .read_en(freq_en),
      .length(freq_len), .shift('0),
      .sample(freq_s), .last(freq_last));

   // per-rate cyclic shift of base sequence
   assign phase_shift = IW'(rate_sel) * IW'(preamble_pkg::PHASE_SHIFT);

   lut_generator #(.IDX_W(IW), .SEED(8'hC5)) phase_gen (
      .clock(clock), .rst(rst), .read_en(phase_en),
      .length(IW'(preamble_pkg::PHASE_LEN)), .shift(phase_shift),
      .sample(phase_s), .last(phase_last));

   // side generator samples registered out
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         freq_sample  <= '0;
         phase_sample <= '0;
      end
      else
      begin
         freq_sample  <= freq_s;
         phase_sample <= phase_s;
      end
   end

   // stop flag latched until frame ends
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         stop_q <= 1'b0;
      else if (tx_end || (state_q != ST_IDLE && !tx_enable))
         stop_q <= 1'b1;
      else if (state_q == ST_IDLE)
         stop_q <= 1'b0;
   end

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (tx_enable && !tx_end && num_subframes != '0)
               state_d = ST_GAIN;
         ST_GAIN:
            if (gain_last)
               state_d = ST_TIMING;
         ST_TIMING:
            if (timing_last && rep_q == '0)
               state_d = (stop_q || tx_end || !tx_enable) ? ST_IDLE : ST_GAIN;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // frame state and timing repeat counter
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         rep_q   <= preamble_pkg::REPEAT_RESET[REPEAT_W-1:0];
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_GAIN && gain_last)
            rep_q <= num_subframes - 1'b1;
         else if (state_q == ST_TIMING && timing_last && rep_q != '0)
            rep_q <= rep_q - 1'b1;
      end
   end

   // enables and select registered from next state
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tx_select <= preamble_pkg::SEL_IDLE;
         gain_en   <= 1'b0;
         timing_en <= 1'b0;
         busy      <= 1'b0;
      end
      else
      begin
         case (state_d)
            ST_GAIN:   tx_select <= preamble_pkg::SEL_GAIN;
            ST_TIMING: tx_select <= preamble_pkg::SEL_TIMING;
            default:   tx_select <= preamble_pkg::SEL_IDLE;
         endcase
         gain_en   <= (state_d == ST_GAIN);
         timing_en <= (state_d == ST_TIMING);
         busy      <= (state_d != ST_IDLE);
      end
   end

   always_comb
   begin
      case (tx_select)
         preamble_pkg::SEL_GAIN:   seg_s = gain_s;
         preamble_pkg::SEL_TIMING: seg_s = timing_s;
         default:                  seg_s = '0;
      endcase
   end

   // rrc half-taps, q1.14, symmetric 17-tap filters
   function automatic logic signed [15:0] rrc_coef(input logic narrow, input int k);
      logic signed [15:0] a [0:8];
      logic signed [15:0] b [0:8];
      a = '{16'sh2C8A, 16'sh2393, 16'sh0E7F, 16'shFC56, 16'shF7E8,
            16'shFDB2, 16'sh0320, 16'sh0192, 16'shFEFB};
      b = '{16'sh2917, 16'sh21D9, 16'sh0F9B, 16'sh00B0, 16'shFAC3,
            16'shFD3E, 16'sh00CB, 16'sh0132, 16'sh0036};
      return narrow ? a[k] : b[k];
   endfunction

   logic signed [15:0] tap_i_q [0:2*preamble_pkg::TAPS-2];
   logic signed [15:0] tap_q_q [0:2*preamble_pkg::TAPS-2];
   logic signed [39:0] acc_i;
   logic signed [39:0] acc_q;
   logic               narrow;
   logic [1:0]         valid_q;

   // 0.22 on select one, else 0.35
   assign narrow = (alpha_sel == preamble_pkg::ALPHA_NARROW);

   // delay line of the shaping filter
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int n = 0; n < 2*preamble_pkg::TAPS-1; n++)
         begin
            tap_i_q[n] <= '0;
            tap_q_q[n] <= '0;
         end
         valid_q <= '0;
      end
      else
      begin
         tap_i_q[0] <= seg_s.i;
         tap_q_q[0] <= seg_s.q;
         for (int n = 1; n < 2*preamble_pkg::TAPS-1; n++)
         begin
            tap_i_q[n] <= tap_i_q[n-1];
            tap_q_q[n] <= tap_q_q[n-1];
         end
         valid_q <= {valid_q[0], busy};
      end
   end

   always_comb
   begin
      acc_i = 40'(tap_i_q[preamble_pkg::TAPS-1]) * 40'(rrc_coef(narrow, 0));
      acc_q = 40'(tap_q_q[preamble_pkg::TAPS-1]) * 40'(rrc_coef(narrow, 0));
      for (int k = 1; k < preamble_pkg::TAPS; k++)
      begin
         acc_i = acc_i + 40'(40'(tap_i_q[preamble_pkg::TAPS-1-k])
                 + 40'(tap_i_q[preamble_pkg::TAPS-1+k])) * 40'(rrc_coef(narrow, k));
         acc_q = acc_q + 40'(40'(tap_q_q[preamble_pkg::TAPS-1-k])
                 + 40'(tap_q_q[preamble_pkg::TAPS-1+k])) * 40'(rrc_coef(narrow, k));
      end
   end

   function automatic logic [15:0] to_unsigned(input logic signed [39:0] v);
      logic signed [39:0] s;
      s = v >>> preamble_pkg::COEF_FRAC;
      if (s > 40'sd32767)
         s = 40'sd32767;
      else if (s < -40'sd32768)
         s = -40'sd32768;
      return s[15:0] ^ 16'h8000;
   endfunction

   // registered dac output
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dac_data  <= {16'h8000, 16'h8000};
         dac_valid <= 1'b0;
      end
      else
      begin
         dac_data.i <= to_unsigned(acc_i);
         dac_data.q <= to_unsigned(acc_q);
         dac_valid  <= valid_q[1];
      end
   end
endmodule // continuous_preamble_tx
`default_nettype wire

// *** rtl/preamble_pkg.sv ***
`default_nettype none
package preamble_pkg;

   // sample carrier: signed I and Q pair
   localparam int SAMPLE_W = 16;
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] i;
      logic signed [SAMPLE_W-1:0] q;
   } iq_t;

   // dac format: offset binary pair
   typedef struct packed {
      logic [SAMPLE_W-1:0] i;
      logic [SAMPLE_W-1:0] q;
   } dac_t;

   // table lengths in oversampled entries
   localparam int OSR          = 2;
   localparam int GAIN_SYMS    = 256;
   localparam int TIMING_SYMS  = 512;
   localparam int GAIN_LEN     = GAIN_SYMS * OSR;
   localparam int TIMING_LEN   = TIMING_SYMS * OSR;
   localparam int FREQ_LEN_0   = 544 * OSR;
   localparam int FREQ_LEN_1   = 1056 * OSR;
   localparam int FREQ_LEN_2   = 2080 * OSR;
   localparam int PHASE_LEN    = 166 * OSR;
   localparam int RATE_COUNT   = 4;
   localparam int PHASE_SHIFT  = 7;
   localparam int IDX_W        = 13;

   // frame segment select codes
   typedef enum logic [1:0] {
      SEL_IDLE   = 2'b00,
      SEL_GAIN   = 2'b01,
      SEL_TIMING = 2'b10
   } seg_sel_t;

   // shaping filter: 9 unique taps of a symmetric 17-tap filter, q1.14 coefficients
   localparam int TAPS      = 9;
   localparam int COEF_W    = 16;
   localparam int COEF_FRAC = 14;
   localparam logic [0:0] ALPHA_NARROW = 1'h1;

   // reset values
   localparam logic [15:0] REPEAT_RESET = 16'h0000;

   // table entry: deterministic per-index pattern with a rotating phase
   function automatic iq_t table_entry(input logic [IDX_W-1:0] idx,
                                       input logic [7:0] seed);
      logic [7:0] p;
      iq_t e;
      p = idx[8:1] ^ seed;
      e.i = p[7] ? 16'shD000 : 16'sh3000;
      e.q = p[6] ? 16'shD000 : 16'sh3000;
      return e;
   endfunction

endpackage
`default_nettype wire

// *** rtl/lut_generator.sv ***
`timescale 1ns/1ns
`default_nettype none
// counter-plus-table generator; contents chosen by seed and shift
module lut_generator #(
   parameter int  IDX_W = 13,
   parameter logic [7:0] SEED = 8'h00
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // control
   input  wire logic                  read_en,
   input  wire logic [IDX_W-1:0]      length,
   input  wire logic [IDX_W-1:0]      shift,
   // sample out
   output preamble_pkg::iq_t          sample,
   output logic                       last
);
   if (IDX_W < 4)
   begin : g_bad_width
      $error("index too narrow");
   end

   logic [IDX_W-1:0] idx_q;
   logic [IDX_W-1:0] addr;

   // index runs while enabled, wraps at length
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         idx_q <= '0;
      else if (!read_en)
         idx_q <= '0;
      else if (idx_q == length - 1'b1)
         idx_q <= '0;
      else
         idx_q <= idx_q + 1'b1;
   end

   // cyclic shift of the base sequence selects table variant
   always_comb
   begin
      addr = idx_q + shift;
      if (addr >= length)
         addr = addr - length;
   end

   assign sample = preamble_pkg::table_entry(addr, SEED);
   assign last   = read_en && (idx_q == length - 1'b1);
endmodule // lut_generator
`default_nettype wire

// *** tb/continuous_preamble_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module continuous_preamble_sva #(
   parameter int REPEAT_W = 16
) (
   // clock and reset
   input wire logic                   clock,
   input wire logic                   rst,
   // control
   input wire logic                   tx_enable,
   input wire logic                   tx_end,
   input wire logic [REPEAT_W-1:0]    num_subframes,
   // status
   input wire preamble_pkg::seg_sel_t tx_select,
   input wire logic                   gain_en,
   input wire logic                   timing_en,
   input wire logic                   busy,
   input wire logic                   dac_valid
);
   int   gcnt_q;
   int   tcnt_q;
   logic stop_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // segment run lengths
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         gcnt_q <= 0;
         tcnt_q <= 0;
      end
      else
      begin
         gcnt_q <= gain_en ? gcnt_q + 1 : 0;
         tcnt_q <= timing_en ? tcnt_q + 1 : 0;
      end
   end

   // stop request seen during the frame
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         stop_q <= 1'b0;
      else
         stop_q <= busy & (stop_q | ~tx_enable | tx_end);
   end

   a_start_gain: assert property (!busy && tx_enable && !tx_end && num_subframes != 0
      |=> gain_en && busy) else $error("start did not enter gain");
   a_start_refused: assert property (!busy && (tx_end || num_subframes == 0)
      |=> !busy) else $error("refused start went busy");
   a_gain_length: assert property ($fell(gain_en)
      |-> gcnt_q == preamble_pkg::GAIN_LEN && timing_en) else $error("gain length wrong");
   a_timing_length: assert property ($fell(timing_en)
      |-> tcnt_q == preamble_pkg::TIMING_LEN * num_subframes) else $error("timing length wrong");
   a_select_decode: assert property (busy == (tx_select != preamble_pkg::SEL_IDLE)
      && gain_en == (tx_select == preamble_pkg::SEL_GAIN)
      && timing_en == (tx_select == preamble_pkg::SEL_TIMING)) else $error("select mismatch");
   a_valid_delay: assert property (dac_valid == $past(busy, 3))
      else $error("valid not busy delayed");
   a_stop_idle: assert property ($fell(timing_en) && stop_q |-> !busy)
      else $error("stop did not idle");
   a_repeat_frame: assert property ($fell(timing_en) && !stop_q
      |-> gain_en) else $error("frame not repeated");
endmodule // continuous_preamble_sva

bind continuous_preamble_tx continuous_preamble_sva #(.REPEAT_W(REPEAT_W)) u_sva (
   .clock(clock),
   .rst(rst),
   .tx_enable(tx_enable),
   .tx_end(tx_end),
   .num_subframes(num_subframes),
   .tx_select(tx_select),
   .gain_en(gain_en),
   .timing_en(timing_en),
   .busy(busy),
   .dac_valid(dac_valid)
);
`default_nettype wire

// *** tb/dac_sink.sv ***
`timescale 1ns/1ns
`default_nettype none
module dac_sink (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // sample stream
   input wire logic dac_valid,
   // observation
   output int       taken
);
   // dac core takes a sample on every valid cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         taken <= 0;
      else if (dac_valid)
         taken <= taken + 1;
   end
endmodule // dac_sink
`default_nettype wire

// *** tb/preamble_frame_generator_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module preamble_frame_generator_bench;
   logic                   clock;
   logic                   rst;
   logic                   tx_enable;
   logic                   tx_end;
   logic [15:0]            num_subframes;
   logic                   alpha_sel;
   logic [1:0]             freq_sel;
   logic [1:0]             rate_sel;
   logic                   freq_en;
   logic                   phase_en;
   preamble_pkg::seg_sel_t tx_select;
   logic                   gain_en;
   logic                   timing_en;
   logic                   busy;
   preamble_pkg::dac_t     dac_data;
   preamble_pkg::iq_t      freq_sample;
   preamble_pkg::iq_t      phase_sample;
   preamble_pkg::iq_t      first_f;
   preamble_pkg::iq_t      first_p;
   logic                   dac_valid;
   int                     taken;
   int                     mismatches;
   int                     checks_done;
   int                     len;

   continuous_preamble_tx u_dut (
      .clock(clock), .rst(rst), .tx_enable(tx_enable), .tx_end(tx_end),
      .num_subframes(num_subframes), .alpha_sel(alpha_sel), .freq_sel(freq_sel),
      .rate_sel(rate_sel), .freq_en(freq_en), .phase_en(phase_en),
      .tx_select(tx_select), .gain_en(gain_en), .timing_en(timing_en), .busy(busy),
      .freq_sample(freq_sample), .phase_sample(phase_sample),
      .dac_data(dac_data), .dac_valid(dac_valid)
   );

   dac_sink u_sink (.clock(clock), .rst(rst), .dac_valid(dac_valid), .taken(taken));

   // 25 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // wait for a segment, then count its cycles
   task automatic run_len(input logic [1:0] code, output int n);
      int guard;
      guard = 0;
      n = 0;
      while (tx_select !== code && guard < 100)
      begin
         tick(1);
         guard++;
      end
      while (tx_select === code)
      begin
         tick(1);
         n++;
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, about twice the expected run
   initial
   begin
      repeat (40000) @(posedge clock);
      mismatches++;
      test_done();
   end

   initial
   begin
      rst = 1'b1;
      tx_enable = 1'b0;
      tx_end = 1'b0;
      num_subframes = 16'h0000;
      alpha_sel = 1'b0;
      freq_sel = 2'h0;
      rate_sel = 2'h0;
      freq_en = 1'b0;
      phase_en = 1'b0;
      mismatches = 0;
      checks_done = 0;
      tick(20);
      rst = 1'b0;
      check("dac_data", dac_data, 32'h80008000);
      // side generators wrap at their length and restart when the enable drops
      for (int k = 0; k < 4; k++)
      begin
         freq_sel = 2'(k);
         rate_sel = 2'(k);
         freq_en = 1'b0;
         phase_en = 1'b0;
         tick(2);
         first_f = freq_sample;
         first_p = phase_sample;
         len = (k == 0) ? preamble_pkg::FREQ_LEN_0
             : (k == 1) ? preamble_pkg::FREQ_LEN_1 : preamble_pkg::FREQ_LEN_2;
         freq_en = 1'b1;
         phase_en = 1'b1;
         tick(preamble_pkg::PHASE_LEN + 1);
         check("phase_wrap", phase_sample, first_p);
         tick(len - preamble_pkg::PHASE_LEN);
         check("freq_wrap", freq_sample, first_f);
         freq_en = 1'b0;
         phase_en = 1'b0;
         tick(2);
         check("freq_restart", freq_sample, first_f);
         check("phase_restart", phase_sample, first_p);
      end
      // starts that must be ignored
      tx_enable = 1'b1;
      tick(5);
      check("busy_no_repeats", busy, 1'h0);
      num_subframes = 16'h0001;
      tx_end = 1'b1;
      tick(5);
      check("busy_stop_held", busy, 1'h0);
      // two frames back to back, permit dropped in the second
      num_subframes = 16'h0002;
      alpha_sel = 1'b1;
      tx_end = 1'b0;
      run_len(2'h1, len);
      check("gain_len", len, 32'h200);
      run_len(2'h2, len);
      check("timing_len", len, 32'h800);
      tx_enable = 1'b0;
      check("tx_select", tx_select, 2'h1);
      run_len(2'h1, len);
      check("gain_len", len, 32'h200);
      run_len(2'h2, len);
      check("timing_len", len, 32'h800);
      check("busy_after_stop", busy, 1'h0);
      tick(3);
      check("taken", taken, 32'h1400);
      // idle feeds zeros, so the filter settles to mid-scale
      tick(20);
      check("dac_idle", dac_data, 32'h80008000);
      // stop by a one-cycle flag in the first timing cycle
      tx_enable = 1'b1;
      num_subframes = 16'h0001;
      alpha_sel = 1'b0;
      run_len(2'h1, len);
      check("gain_len", len, 32'h200);
      tx_end = 1'b1;
      tick(1);
      tx_end = 1'b0;
      run_len(2'h2, len);
      check("timing_len", len + 1, 32'h400);
      check("busy_after_flag", busy, 1'h0);
      // reset in mid frame
      run_len(2'h1, len);
      rst = 1'b1;
      tx_enable = 1'b0;
      #1;
      check("dac_data_rst", dac_data, 32'h80008000);
      check("busy_rst", busy, 1'h0);
      tick(4);
      rst = 1'b0;
      tick(5);
      check("busy_no_permit", busy, 1'h0);
      test_done();
   end
endmodule // preamble_frame_generator_bench
`default_nettype wire
